// File: scp_pkg.sv
`default_nettype none
package scp_pkg;

  localparam int CLK_HZ = 50_000_000;

  // selectable line rates, index is the CTRL baud field
  localparam int BAUD_N = 14;
  localparam int BAUD_TAB [BAUD_N] = '{300, 600, 1200, 2400, 4800, 9600, 14400, 19200,
                                       28800, 38400, 57600, 115200, 230400, 460800};
  localparam logic [3:0] BAUD_IDX_1200 = 4'h2;
  localparam logic [3:0] BAUD_IDX_9600 = 4'h5;
  localparam logic [3:0] BAUD_IDX_MAX  = 4'hD;

  // tone frequencies for the loop modulator
  localparam int FSK_ZERO_HZ = 2200;
  localparam int FSK_ONE_HZ  = 1200;

  // register word offsets, matched against byte address bits 7:2
  localparam logic [5:0] REG_CTRL     = 6'h00;
  localparam logic [5:0] REG_STATUS   = 6'h01;
  localparam logic [5:0] REG_TXDATA   = 6'h02;
  localparam logic [5:0] REG_RXDATA   = 6'h03;
  localparam logic [5:0] REG_LOOP     = 6'h04;
  localparam logic [5:0] REG_PREAMBLE = 6'h05;
  localparam logic [5:0] REG_TRIM     = 6'h06;
  localparam logic [5:0] REG_LOWCODE  = 6'h07;
  localparam logic [5:0] REG_FULLCODE = 6'h08;
  localparam logic [5:0] REG_DACCODE  = 6'h09;

  // field positions
  localparam int CTRL_FMT_LSB   = 4;
  localparam int CTRL_IF_LSB    = 6;
  localparam int CTRL_PROTO_LSB = 8;
  localparam int ST_PAR_ERR     = 2;
  localparam int ST_FRM_ERR     = 3;
  localparam int TX_MSG_BIT     = 8;
  localparam int LOOP_MA_LSB    = 8;
  localparam int LOOP_STN_LSB   = 16;
  localparam int TRIM_UP_BIT    = 2;
  localparam int TRIM_DN_BIT    = 3;

  // reset and limit values
  localparam logic [15:0] LOW_CODE_RST      = 16'h019C;
  localparam logic [15:0] FULL_CODE_FACTORY = 16'h34C8;
  localparam logic [4:0]  PREAMBLE_RST      = 5'h05;
  localparam logic [4:0]  PREAMBLE_MIN      = 5'h03;
  localparam logic [4:0]  PREAMBLE_MAX      = 5'h14;
  localparam logic [7:0]  FORCE_MA10_RST    = 8'h28;
  localparam logic [7:0]  FORCE_MA10_MIN    = 8'h23;
  localparam logic [7:0]  FORCE_MA10_MAX    = 8'hDC;
  localparam logic [7:0]  LOOP_ZERO_MA10    = 8'h28;
  // 65536 / 160 tenths of a milliamp across the 4..20 span
  localparam logic [17:0] FORCE_SCALE       = 18'h0019A;
  localparam int          FSK_AMP_SHIFT     = 5;
  localparam logic [1:0]  PROTO_CAP_CNT     = 2'h3;

  typedef enum logic [1:0] {
    FMT_N81 = 2'b00, FMT_N82 = 2'b01, FMT_E81 = 2'b10, FMT_O81 = 2'b11
  } scp_fmt_t;
  typedef enum logic [1:0] {
    PROTO_ASCII = 2'b00, PROTO_MODBUS = 2'b01, PROTO_HART = 2'b10, PROTO_NONE = 2'b11
  } scp_proto_t;
  typedef enum logic [1:0] {
    IF_RS232 = 2'b00, IF_RS485 = 2'b01, IF_FSK = 2'b10, IF_RSVD = 2'b11
  } scp_iface_t;
  typedef enum logic [1:0] {
    TRIM_OFF = 2'b00, TRIM_LOW = 2'b01, TRIM_FULL = 2'b10, TRIM_RSVD = 2'b11
  } scp_trim_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10, RX_RSVD = 2'b11
  } scp_rx_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } scp_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } scp_wb_rsp_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [1:0]  proto_s1;
    logic [1:0]  proto_s2;
    logic [1:0]  proto_cnt;
    scp_proto_t  proto;
    logic        rxd_s1;
    logic        rxd_s2;
    logic [3:0]  baud;
    scp_fmt_t    fmt;
    scp_iface_t  iface;
    logic [3:0]  station;
    logic        force_en;
    logic [7:0]  force_ma10;
    logic [4:0]  preamble;
    scp_trim_t   trim;
    logic [15:0] low_code;
    logic [15:0] full_code;
    logic [15:0] dac;
    logic        tx_busy;
    logic        tx_pend;
    logic [11:0] tx_sh;
    logic [3:0]  tx_left;
    logic [17:0] tx_cnt;
    logic        fsk_half;
    logic [7:0]  tx_byte;
    logic [4:0]  pre_left;
    scp_rx_t     rx_st;
    logic [17:0] rx_cnt;
    logic [3:0]  rx_idx;
    logic [10:0] rx_sh;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        par_err;
    logic        frm_err;
  } scp_state_t;

endpackage
`default_nettype wire

// File: scp_serial_port.sv
`timescale 1ns/10ps
`default_nettype none
module scp_serial_port #(
  parameter int CLK_HZ        = scp_pkg::CLK_HZ,
  parameter int FSK_HALF_ONE  = CLK_HZ / (2 * scp_pkg::FSK_ONE_HZ),
  parameter int FSK_HALF_ZERO = CLK_HZ / (2 * scp_pkg::FSK_ZERO_HZ)
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire scp_pkg::scp_wb_req_t wb_req_i,
  output var  scp_pkg::scp_wb_rsp_t wb_rsp_o,
  input  wire logic [1:0]           protocol_i,
  input  wire logic                 rxd_i,
  input  wire logic [15:0]          live_frac_i,
  output logic                      txd_o,
  output logic                      rs232_sel_o,
  output logic                      rs485_de_o,
  output logic                      fsk_sel_o,
  output logic [15:0]               dac_code_o
);
  import scp_pkg::*;

  scp_state_t  q;
  scp_state_t  n;
  logic [17:0] div_tab [BAUD_N];

  // divisors stay constants so no runtime divider is built
  for (genvar g = 0; g < BAUD_N; g++)
  begin : g_div
    assign div_tab[g] = 18'(CLK_HZ / BAUD_TAB[g]);
  end

  function automatic logic [11:0] frame_of(input logic [7:0] b, input scp_fmt_t f);
    logic p;
    p = ^b;
    case (f)
      FMT_E81: frame_of = {2'b11, p, b, 1'b0};
      FMT_O81: frame_of = {2'b11, ~p, b, 1'b0};
      default: frame_of = {3'b111, b, 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] len_of(input scp_fmt_t f);
    len_of = (f == FMT_N81) ? 4'hA : 4'hB;
  endfunction

  always_comb
  begin
    logic             hart;
    logic [3:0]       baud_eff;
    scp_fmt_t         fmt_eff;
    logic [17:0]      div;
    logic [17:0]      half;
    logic             req;
    logic [31:0]      rd_val;
    logic [31:0]      mask;
    logic [31:0]      mval;
    logic             tick;
    logic [10:0]      sh_v;
    logic             bit_ok;
    logic signed [16:0] span;
    logic signed [17:0] frac;
    logic signed [35:0] prod;
    logic [15:0]      base;
    logic [15:0]      amp;
    scp_trim_t        tmode;
    hart     = 1'b0;
    baud_eff = 4'h0;
    fmt_eff  = FMT_N81;
    div      = 18'h0;
    half     = 18'h0;
    req      = 1'b0;
    rd_val   = 32'h0;
    mask     = 32'h0;
    mval     = 32'h0;
    tick     = 1'b0;
    sh_v     = 11'h0;
    bit_ok   = 1'b0;
    span     = 17'sh0;
    frac     = 18'sh0;
    prod     = 36'sh0;
    base     = 16'h0;
    amp      = 16'h0;
    tmode    = TRIM_OFF;
    n = q;
    n.proto_s1 = protocol_i;
    n.proto_s2 = q.proto_s1;
    n.rxd_s1   = rxd_i;
    n.rxd_s2   = q.rxd_s1;
    // strap caught once after the synchroniser has filled, never changed later
    if (q.proto_cnt != PROTO_CAP_CNT)
      n.proto_cnt = q.proto_cnt + 2'h1;
    if (q.proto_cnt == PROTO_CAP_CNT - 2'h1)
      n.proto = scp_proto_t'(q.proto_s2);

    hart     = (q.proto == PROTO_HART);
    baud_eff = hart ? BAUD_IDX_1200 : q.baud;
    fmt_eff  = hart ? FMT_O81 : q.fmt;
    div      = div_tab[baud_eff];
    case (wb_req_i.adr[7:2])
      REG_CTRL:     rd_val = {22'h0, q.proto, hart ? IF_FSK : q.iface, fmt_eff, baud_eff};
      REG_STATUS:   rd_val = {28'h0, q.frm_err, q.par_err, q.rx_valid, q.tx_busy};
      REG_RXDATA:   rd_val = {24'h0, q.rx_data};
      REG_LOOP:     rd_val = {12'h0, q.station, q.force_ma10, 7'h0, q.force_en};
      REG_PREAMBLE: rd_val = {27'h0, q.preamble};
      REG_TRIM:     rd_val = {30'h0, q.trim};
      REG_LOWCODE:  rd_val = {16'h0, q.low_code};
      REG_FULLCODE: rd_val = {16'h0, q.full_code};
      REG_DACCODE:  rd_val = {16'h0, q.dac};
      default:      rd_val = 32'h0;
    endcase
    mask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}}, {8{wb_req_i.sel[1]}},
            {8{wb_req_i.sel[0]}}};
    mval = (rd_val & ~mask) | (wb_req_i.dat & mask);

    req   = wb_req_i.cyc && wb_req_i.stb && !q.ack;
    n.ack = req;
    if (req)
      n.rdat = rd_val;
    if (req && !wb_req_i.we && wb_req_i.adr[7:2] == REG_RXDATA)
      n.rx_valid = 1'b0;
    if (req && wb_req_i.we)
    begin
      case (wb_req_i.adr[7:2])
        REG_CTRL:
        begin
          // locked under HART; an out of range rate index is dropped
          if (!hart)
          begin
            if (mval[3:0] <= BAUD_IDX_MAX)
              n.baud = mval[3:0];
            n.fmt = scp_fmt_t'(mval[CTRL_FMT_LSB +: 2]);
            if (mval[CTRL_IF_LSB +: 2] == IF_RS232 || mval[CTRL_IF_LSB +: 2] == IF_RS485)
              n.iface = scp_iface_t'(mval[CTRL_IF_LSB +: 2]);
          end
        end
        REG_STATUS:
        begin
          n.par_err = q.par_err && !mval[ST_PAR_ERR];
          n.frm_err = q.frm_err && !mval[ST_FRM_ERR];
        end
        REG_TXDATA:
        begin
          // a write while busy is dropped; software polls tx_busy
          if (!q.tx_busy)
          begin
            n.tx_byte  = mval[7:0];
            n.tx_pend  = 1'b1;
            n.tx_busy  = 1'b1;
            n.tx_left  = 4'h0;
            n.pre_left = (hart && mval[TX_MSG_BIT]) ? q.preamble : 5'h0;
          end
        end
        REG_LOOP:
        begin
          n.force_en = mval[0];
          n.station  = mval[LOOP_STN_LSB +: 4];
          if (mval[LOOP_MA_LSB +: 8] < FORCE_MA10_MIN)
            n.force_ma10 = FORCE_MA10_MIN;
          else if (mval[LOOP_MA_LSB +: 8] > FORCE_MA10_MAX)
            n.force_ma10 = FORCE_MA10_MAX;
          else
            n.force_ma10 = mval[LOOP_MA_LSB +: 8];
        end
        REG_PREAMBLE:
        begin
          if (mval[4:0] < PREAMBLE_MIN)
            n.preamble = PREAMBLE_MIN;
          else if (mval[4:0] > PREAMBLE_MAX)
            n.preamble = PREAMBLE_MAX;
          else
            n.preamble = mval[4:0];
        end
        REG_TRIM:
        begin
          tmode  = scp_trim_t'(mval[1:0]);
          n.trim = (tmode == TRIM_RSVD) ? TRIM_OFF : tmode;
          if (tmode == TRIM_FULL && q.trim != TRIM_FULL)
            n.full_code = FULL_CODE_FACTORY;
          else if (tmode == TRIM_LOW)
          begin
            if (mval[TRIM_UP_BIT])
              n.low_code = q.low_code + 16'h1;
            else if (mval[TRIM_DN_BIT])
              n.low_code = q.low_code - 16'h1;
          end
          else if (tmode == TRIM_FULL)
          begin
            if (mval[TRIM_UP_BIT])
              n.full_code = q.full_code + 16'h1;
            else if (mval[TRIM_DN_BIT])
              n.full_code = q.full_code - 16'h1;
          end
        end
        REG_LOWCODE:  n.low_code = mval[15:0];
        REG_FULLCODE: n.full_code = mval[15:0];
        default:      n.ack = req;
      endcase
    end

    // transmitter: under HART each bit lasts exactly one tone cycle
    if (q.tx_busy && q.tx_left == 4'h0)
    begin
      n.tx_cnt   = 18'h0;
      n.fsk_half = 1'b0;
      if (q.pre_left != 5'h0)
      begin
        n.tx_sh    = frame_of(8'hFF, fmt_eff);
        n.tx_left  = len_of(fmt_eff);
        n.pre_left = q.pre_left - 5'h1;
      end
      else if (q.tx_pend)
      begin
        n.tx_sh   = frame_of(q.tx_byte, fmt_eff);
        n.tx_left = len_of(fmt_eff);
        n.tx_pend = 1'b0;
      end
      else
      begin
        n.tx_busy = 1'b0;
      end
    end
    else if (q.tx_busy)
    begin
      n.tx_cnt = q.tx_cnt + 18'h1;
      if (hart)
      begin
        half = q.tx_sh[0] ? 18'(FSK_HALF_ONE) : 18'(FSK_HALF_ZERO);
        if (q.tx_cnt >= half - 18'h1)
        begin
          n.tx_cnt   = 18'h0;
          n.fsk_half = !q.fsk_half;
          tick       = q.fsk_half;
        end
      end
      else if (q.tx_cnt >= div - 18'h1)
      begin
        n.tx_cnt = 18'h0;
        tick     = 1'b1;
      end
      if (tick)
      begin
        n.tx_sh   = {1'b1, q.tx_sh[11:1]};
        n.tx_left = q.tx_left - 4'h1;
      end
    end

    // receiver samples mid-bit; start bit rechecked at its centre
    case (q.rx_st)
      RX_IDLE:
      begin
        n.rx_cnt = 18'h0;
        if (!q.rxd_s2)
          n.rx_st = RX_START;
      end
      RX_START:
      begin
        n.rx_cnt = q.rx_cnt + 18'h1;
        if (q.rx_cnt >= (div >> 1))
        begin
          n.rx_cnt = 18'h0;
          n.rx_idx = 4'h0;
          n.rx_st  = q.rxd_s2 ? RX_IDLE : RX_BITS;
        end
      end
      RX_BITS:
      begin
        n.rx_cnt = q.rx_cnt + 18'h1;
        if (q.rx_cnt >= div - 18'h1)
        begin
          n.rx_cnt         = 18'h0;
          sh_v             = q.rx_sh;
          sh_v[q.rx_idx]   = q.rxd_s2;
          n.rx_sh          = sh_v;
          n.rx_idx         = q.rx_idx + 4'h1;
          if (q.rx_idx == len_of(fmt_eff) - 4'h2)
          begin
            n.rx_st    = RX_IDLE;
            n.rx_data  = sh_v[7:0];
            n.rx_valid = 1'b1;
            case (fmt_eff)
              FMT_N81: bit_ok = sh_v[8];
              FMT_N82: bit_ok = sh_v[8] & sh_v[9];
              default: bit_ok = sh_v[9];
            endcase
            // setting wins over a clear in the same cycle
            if (!bit_ok)
              n.frm_err = 1'b1;
            if (fmt_eff == FMT_E81 && (^sh_v[8:0]))
              n.par_err = 1'b1;
            if (fmt_eff == FMT_O81 && !(^sh_v[8:0]))
              n.par_err = 1'b1;
          end
        end
      end
      default: n.rx_st = RX_IDLE;
    endcase

    // loop code: live_frac_i passes in only, the measured value is never written
    span = $signed({1'b0, q.full_code}) - $signed({1'b0, q.low_code});
    if (q.force_en)
      frac = $signed({10'h0, q.force_ma10}) - $signed({10'h0, LOOP_ZERO_MA10});
    else
      frac = $signed({2'b00, live_frac_i});
    if (q.force_en)
      frac = 18'(frac * $signed(FORCE_SCALE));
    prod = 36'(span * frac);
    if (q.trim == TRIM_LOW)
      base = q.low_code;
    else if (q.trim == TRIM_FULL)
      base = q.full_code;
    else if (!q.force_en && q.station != 4'h0)
      base = q.low_code;
    else
      base = 16'(q.low_code + 16'(prod >>> 16));
    // half a milliamp is 1/32 of the 16 mA span
    amp = 16'(span >>> FSK_AMP_SHIFT);
    if (hart && q.tx_busy && q.tx_left != 4'h0)
      n.dac = q.fsk_half ? base - amp : base + amp;
    else
      n.dac = base;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q            <= '0; // zero codes: ASCII, RS232, trim off, receiver idle
      q.baud       <= BAUD_IDX_9600;
      q.fmt        <= FMT_N81;
      q.force_ma10 <= FORCE_MA10_RST;
      q.preamble   <= PREAMBLE_RST;
      q.low_code   <= LOW_CODE_RST;
      q.full_code  <= FULL_CODE_FACTORY;
      q.tx_sh      <= 12'hFFF;
      q.rxd_s1     <= 1'b1;
      q.rxd_s2     <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  assign wb_rsp_o.ack = q.ack;
  assign wb_rsp_o.dat = q.rdat;
  assign txd_o        = q.tx_sh[0];
  assign fsk_sel_o    = (q.proto == PROTO_HART);
  assign rs232_sel_o  = !fsk_sel_o && q.iface == IF_RS232;
  assign rs485_de_o   = !fsk_sel_o && q.iface == IF_RS485 && q.tx_busy;
  assign dac_code_o   = q.dac;

endmodule // scp_serial_port
`default_nettype wire

// File: scp_serial_port_chk.sv
`timescale 1ns/10ps
`default_nettype none
module scp_serial_port_chk (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire scp_pkg::scp_wb_req_t wb_req_i,
  input wire scp_pkg::scp_wb_rsp_t wb_rsp_o,
  input wire logic [1:0]           protocol_i,
  input wire logic                 rxd_i,
  input wire logic [15:0]          live_frac_i,
  input wire logic                 txd_o,
  input wire logic                 rs232_sel_o,
  input wire logic                 rs485_de_o,
  input wire logic                 fsk_sel_o,
  input wire logic [15:0]          dac_code_o
);
  import scp_pkg::*;
  // counts edges since reset, holding at 7; the strap is only valid once captured
  logic [2:0] up_cnt_r;
  always_ff @(posedge clk_i)
    if (rst_i)
      up_cnt_r <= 3'h0;
    else if (up_cnt_r != 3'h7)
      up_cnt_r <= up_cnt_r + 3'h1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence wb_take;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  sequence wb_rd(a);
    wb_take ##0 (!wb_req_i.we && wb_req_i.adr[7:2] == a);
  endsequence

  ack_follows_a: assert property (wb_take |=> wb_rsp_o.ack)
    else $error("request not acknowledged");
  ack_single_a: assert property (wb_rsp_o.ack |-> $past(wb_req_i.stb) ##1 !wb_rsp_o.ack)
    else $error("ack not a single answer");
  unmapped_zero_a: assert property (wb_take ##0 (!wb_req_i.we && wb_req_i.adr[7:2] > REG_DACCODE)
    |=> wb_rsp_o.dat == 32'h0) else $error("unmapped read not zero");
  proto_ro_a: assert property (wb_rd(REG_CTRL) ##0 up_cnt_r == 3'h7
    |=> wb_rsp_o.dat[9:8] == $past(protocol_i)) else $error("protocol field wrong");
  hart_lock_a: assert property (wb_rd(REG_CTRL) ##0 fsk_sel_o
    |=> wb_rsp_o.dat[7:0] == 8'hB2) else $error("locked settings wrong");
  iface_excl_a: assert property ($onehot0({rs232_sel_o, rs485_de_o, fsk_sel_o}))
    else $error("two interfaces active");
  fsk_strap_a: assert property (up_cnt_r == 3'h7 |-> fsk_sel_o == (protocol_i == 2'h2))
    else $error("modem selection wrong");
  tx_start_a: assert property ($rose(rs485_de_o) |=> !txd_o)
    else $error("start bit missing");
  tx_stop_a: assert property ($fell(rs485_de_o) |-> $past(txd_o) && txd_o)
    else $error("stop level missing");
endmodule // scp_serial_port_chk
`default_nettype wire

// File: scp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module scp_host_model (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output var  logic rxd_o
);
  int div = 104;
  int fmt = 0;
  // released line sits at the marking level of the pull-up
  initial rxd_o = 1'b1;
  function automatic logic par_of(input logic [7:0] b);
    return (fmt == 3) ? ~^b : ^b;
  endfunction
  // mode 1 spoils the parity bit, mode 2 the last stop bit
  task automatic put_byte(input logic [7:0] b, input int mode);
    logic [10:0] f;
    int          n;
    n = (fmt == 0) ? 10 : 11;
    f = {1'b1, (fmt >= 2) ? par_of(b) ^ (mode == 1) : 1'b1, b, 1'b0};
    if (mode == 2)
      f[n-1] = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (div - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (txd_i !== 1'b0 && n < 20 * div)
    begin
      @(negedge clk_i);
      n++;
    end
    repeat (div / 2) @(negedge clk_i);
    ok = (txd_i === 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      repeat (div) @(negedge clk_i);
      b[i] = txd_i;
    end
    if (fmt >= 2)
    begin
      repeat (div) @(negedge clk_i);
      ok = ok && (txd_i === par_of(b));
    end
    for (int i = (fmt == 1) ? 0 : 1; i < 2; i++)
    begin
      repeat (div) @(negedge clk_i);
      ok = ok && (txd_i === 1'b1);
    end
  endtask
endmodule // scp_host_model
`default_nettype wire

// File: scp_serial_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module scp_serial_port_tb;
  import scp_pkg::*;
  localparam int CLKF = 1_000_000;
  localparam int FH1  = 10;
  localparam int FH0  = 6;
  localparam logic [5:0] RA [8] = '{REG_CTRL, REG_STATUS, REG_LOOP, REG_PREAMBLE, REG_TRIM,
                                    REG_LOWCODE, REG_FULLCODE, 6'h0A};
  localparam logic [31:0] RV [8] = '{32'h5, 32'h0, 32'h2800, 32'h5, 32'h0, 32'h19C,
                                     32'h34C8, 32'h0};
  localparam logic [31:0] PW [3] = '{32'h2, 32'h19, 32'h3};
  localparam logic [31:0] PR [3] = '{32'h3, 32'h14, 32'h3};
  logic        clk_i       = 1'b0;
  logic        rst_i       = 1'b1;
  scp_wb_req_t wb_req_i    = '0;
  logic [1:0]  protocol_i  = 2'h0;
  logic [15:0] live_frac_i = 16'h0000;
  logic [15:0] lfsr_q      = 16'h0047;
  scp_wb_rsp_t wb_rsp_o;
  logic [15:0] dac_code_o;
  logic [31:0] q;
  logic        rxd_i, txd_o, rs232_sel_o, rs485_de_o, fsk_sel_o;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          lo, fu, hi_n, lo_n, e;

  initial forever #10 clk_i = ~clk_i;

  scp_serial_port #(.CLK_HZ(CLKF), .FSK_HALF_ONE(FH1), .FSK_HALF_ZERO(FH0)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .protocol_i(protocol_i), .rxd_i(rxd_i), .live_frac_i(live_frac_i), .txd_o(txd_o),
    .rs232_sel_o(rs232_sel_o), .rs485_de_o(rs485_de_o), .fsk_sel_o(fsk_sel_o),
    .dac_code_o(dac_code_o));
  scp_host_model host (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int loop_exp(input int x);
    return lo + (((fu - lo) * x) >>> 16);
  endfunction
  function automatic int tone(input int ones, input int zeros);
    return ones * FH1 + zeros * FH0;
  endfunction

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic miss(input string m);
    $display("unexpected at %0t: %s", $time, m);
    fail_count++;
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
      miss($sformatf("read %h want %h", got, exp));
  endtask
  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
      miss($sformatf("port %h want %h", got, exp));
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {a, 2'b00}, sel: 4'hF, dat: d};
    // ack and read data are taken at the rising edge that samples ack high
    do @(posedge clk_i); while (wb_rsp_o.ack !== 1'b1 && ++n < 50);
    q = wb_rsp_o.dat;
    wb_req_i <= '0;
    if (n >= 50)
      miss("no bus answer");
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do wb(1'b0, REG_STATUS, 32'h0); while (q[b] !== v && ++n < 400);
    if (n >= 400)
      miss("status stuck");
  endtask
  task automatic dac_is(input int x);
    repeat (3) @(negedge clk_i);
    chk_out({16'h0, dac_code_o}, 32'(x));
  endtask
  task automatic do_reset(input logic [1:0] p);
    @(posedge clk_i);
    rst_i <= 1'b1;
    protocol_i <= p;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    lo = 412;
    fu = 13512;
  endtask

  initial
  begin
    logic [7:0] b, g;
    logic       ok;
    do_reset(2'h0);
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b0, RA[i], 32'h0);
      chk_rd(q, RV[i]);
    end
    chk_out(32'(rs232_sel_o), 32'h1);
    $display("test done: reset values");
    for (int i = 0; i < 16; i++)
    begin
      wb(1'b1, REG_CTRL, 32'(i));
      wb(1'b0, REG_CTRL, 32'h0);
      chk_rd({28'h0, q[3:0]}, 32'((i < 14) ? i : 13));
    end
    $display("test done: rate select");
    host.div = CLKF / BAUD_TAB[11];
    for (int f = 0; f < 4; f++)
    begin
      host.fmt = f;
      lfsr_q = lfsr_next(lfsr_q);
      b = lfsr_q[7:0];
      wb(1'b1, REG_CTRL, 32'h4B | (32'(f) << 4));
      wb(1'b1, REG_TXDATA, {24'h0, b});
      host.get_byte(g, ok);
      chk_out({24'h0, g}, {24'h0, b});
      chk_out(32'(ok), 32'h1);
      chk_out(32'(rs485_de_o), 32'h1);
      poll(0, 1'b0);
    end
    $display("test done: transmit formats");
    host.fmt = 2;
    wb(1'b1, REG_CTRL, 32'h6B);
    for (int m = 0; m < 3; m++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      b = lfsr_q[7:0];
      host.put_byte(b, m);
      poll((m == 0) ? 1 : m + 1, 1'b1);
      chk_rd(q & 32'hC, 32'(4 * m));
      wb(1'b0, REG_RXDATA, 32'h0);
      if (m == 0)
        chk_rd(q, {24'h0, b});
      wb(1'b1, REG_STATUS, 32'hC);
      wb(1'b0, REG_STATUS, 32'h0);
      chk_rd(q & 32'hC, 32'h0);
    end
    $display("test done: receive errors");
    for (int i = 0; i < 3; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      @(posedge clk_i);
      live_frac_i <= lfsr_q;
      dac_is(loop_exp(int'(lfsr_q)));
    end
    wb(1'b1, REG_LOOP, 32'h6401);
    dac_is(lo + (((fu - lo) * 60 * 410) >>> 16));
    wb(1'b1, REG_LOOP, 32'hFF01);
    dac_is(lo + (((fu - lo) * 180 * 410) >>> 16));
    wb(1'b0, REG_LOOP, 32'h0);
    chk_rd(q, 32'hDC01);
    wb(1'b1, REG_LOOP, 32'h0001);
    wb(1'b0, REG_LOOP, 32'h0);
    chk_rd(q, 32'h2301);
    wb(1'b1, REG_LOOP, 32'h52800);
    dac_is(lo);
    wb(1'b0, REG_DACCODE, 32'h0);
    chk_rd(q, 32'(lo));
    wb(1'b1, REG_LOOP, 32'h2800);
    dac_is(loop_exp(int'(lfsr_q)));
    wb(1'b1, REG_TRIM, 32'h5);
    lo++;
    dac_is(lo);
    wb(1'b1, REG_TRIM, 32'hD);
    lo++;
    dac_is(lo);
    wb(1'b0, REG_LOWCODE, 32'h0);
    chk_rd(q, 32'(lo));
    wb(1'b1, REG_FULLCODE, 32'h3000);
    wb(1'b1, REG_TRIM, 32'hA);
    dac_is(13512);
    wb(1'b1, REG_TRIM, 32'hA);
    fu--;
    dac_is(fu);
    wb(1'b1, REG_TRIM, 32'h0);
    dac_is(loop_exp(int'(lfsr_q)));
    $display("test done: loop output");
    do_reset(2'h2);
    wb(1'b0, REG_CTRL, 32'h0);
    chk_rd(q, 32'h2B2);
    wb(1'b1, REG_CTRL, 32'h15);
    wb(1'b0, REG_CTRL, 32'h0);
    chk_rd(q, 32'h2B2);
    chk_out(32'(fsk_sel_o), 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, REG_PREAMBLE, PW[i]);
      wb(1'b0, REG_PREAMBLE, 32'h0);
      chk_rd(q, PR[i]);
    end
    lfsr_q = lfsr_next(lfsr_q);
    @(posedge clk_i);
    live_frac_i <= lfsr_q;
    b = lfsr_q[15:8];
    repeat (3) @(posedge clk_i);
    e = loop_exp(int'(lfsr_q));
    hi_n = 0;
    lo_n = 0;
    wb(1'b1, REG_TXDATA, {23'h0, 1'b1, b});
    repeat (1500)
    begin
      @(negedge clk_i);
      hi_n += int'(dac_code_o === 16'(e + ((fu - lo) >>> 5)));
      lo_n += int'(dac_code_o === 16'(e - ((fu - lo) >>> 5)));
    end
    e = 3 * tone(10, 1) + tone($countones(b) + int'(~^b) + 1, 9 - $countones(b) + int'(^b));
    chk_out(32'(hi_n), 32'(e));
    chk_out(32'(lo_n), 32'(e));
    $display("test done: modem message");
    finish_test;
  end

  // the whole sequence needs well under ten thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miss("watchdog expired");
    finish_test;
  end
endmodule // scp_serial_port_tb

bind scp_serial_port scp_serial_port_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .protocol_i(protocol_i), .rxd_i(rxd_i), .live_frac_i(live_frac_i), .txd_o(txd_o),
  .rs232_sel_o(rs232_sel_o), .rs485_de_o(rs485_de_o), .fsk_sel_o(fsk_sel_o),
  .dac_code_o(dac_code_o));
`default_nettype wire
